// *** verilog/usb_tfc_pkg.sv ***
// Constants, types and helpers shared by the USB token and frame control block
package usb_tfc_pkg;

  // Register byte offsets on the APB bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FRAME_HIGH = 8'h04;
  localparam logic [7:0] OFS_TOKEN = 8'h08;

  // Control register field positions
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_PP_RESET_BIT = 1;
  localparam int CTL_RESUME_BIT = 2;
  localparam int CTL_HOST_BIT = 3;
  localparam int CTL_BUSY_BIT = 5;

  // Token register and frame number fields
  localparam int TOK_EP_LSB = 0;
  localparam int TOK_PID_LSB = 4;
  localparam int TOK_FIELD_W = 4;
  localparam int FRAME_NUMBER_UPPER_W = 3;
  localparam int FRAME_NUM_W = 11;

  // Reset values
  localparam logic CTL_BIT_RESET = 1'b0;
  localparam logic [3:0] TOK_FIELD_RESET = 4'h0;
  localparam logic [2:0] FRAME_NUMBER_UPPER_RESET = 3'h0;
  localparam logic [10:0] FRAME_NUM_RESET = 11'h000;

  // Token type codes
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hD;

  // Frame-start spacing derived from the clock rate
  localparam int CLK_PERIOD_NS = 8;
  localparam int FRAME_PERIOD_NS = 1000000;
  localparam int FRAME_PERIOD_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;

  // Token engine states
  typedef enum logic [0:0]
  {
    ENG_IDLE = 1'b0,
    ENG_WAIT = 1'b1
  } eng_state_t;

  // True for the three defined token codes
  function automatic logic pid_defined(input logic [3:0] pid);
    pid_defined = (pid == PID_OUT) || (pid == PID_IN) || (pid == PID_SETUP);
  endfunction : pid_defined

  // True when the token moves data toward this host
  function automatic logic pid_is_receive(input logic [3:0] pid);
    pid_is_receive = (pid == PID_IN);
  endfunction : pid_is_receive

endpackage : usb_tfc_pkg

// *** verilog/usb_token_engine.sv ***
// Token transaction sequencer: issues one token and stays busy until it completes
`timescale 1ns/1ps
`default_nettype none

module usb_token_engine
  import usb_tfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic start,
  input wire logic [3:0] pid,
  input wire logic [3:0] ep,
  input wire logic done,
  output logic busy,
  output logic issue,
  output logic [3:0] issue_pid,
  output logic [3:0] issue_ep,
  output logic issue_rx
);

  typedef struct packed
  {
    eng_state_t state;
    logic busy;
    logic issue;
    logic [3:0] pid;
    logic [3:0] ep;
    logic rx;
  } eng_t;

  eng_t s;
  eng_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Next state; a clear from the host reset beats any pending start
  always_comb
  begin
    next_s = s;
    next_s.issue = 1'b0;
    if (clear)
    begin
      next_s.state = ENG_IDLE;
      next_s.busy = 1'b0;
    end
    else
    begin
      unique case (s.state)
        ENG_IDLE:
        begin
          // Reserved codes are dropped rather than sent on the bus
          if (start && pid_defined(pid))
          begin
            next_s.state = ENG_WAIT;
            next_s.busy = 1'b1;
            next_s.issue = 1'b1;
            next_s.pid = pid;
            next_s.ep = ep;
            next_s.rx = pid_is_receive(pid);
          end
        end
        ENG_WAIT:
        begin
          if (done)
          begin
            next_s.state = ENG_IDLE;
            next_s.busy = 1'b0;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign busy = s.busy;
  assign issue = s.issue;
  assign issue_pid = s.pid;
  assign issue_ep = s.ep;
  assign issue_rx = s.rx;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer
  property p_issue_decode;
    @(posedge clk) disable iff (!rst_n)
    issue |-> (issue_rx == (issue_pid == PID_IN)) && pid_defined(issue_pid);
  endproperty
  a_issue_decode: assert property (p_issue_decode) else $error("token decode wrong");

  property p_busy_holds;
    @(posedge clk) disable iff (!rst_n)
    busy && !done && !clear |=> busy;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");

endmodule : usb_token_engine

`default_nettype wire

// *** verilog/usb_token_frame_control.sv ***
// USB control, token issue and frame-number logic with an APB register slave
//
// How it works
// - Ping-pong reset bit returns pointers to even
// - Device mode: enable bit powers the module
// - Host mode: enable bit sends a frame-start token each millisecond
// - Host-mode bit toggle resets host logic
// - Host resume clear appends low-speed end-of-packet
// - Frame high bits refresh on received frame-start
// - Token codes select setup, in, out
// - Frame high upper bits read zero
// - Token upper bits zero, fields reset zero
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module usb_token_frame_control
  import usb_tfc_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_PERIOD_CYCLES
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic SOF_RX_VALID,
  input wire logic [FRAME_NUM_W-1:0] SOF_RX_FRAME,
  input wire logic TOKEN_DONE,
  output logic MODULE_ENABLE,
  output logic PINGPONG_POINTER_RESET,
  output logic HOST_LOGIC_RESET,
  output logic SOF_TX,
  output logic [FRAME_NUM_W-1:0] SOF_TX_FRAME,
  output logic TOKEN_ISSUE,
  output logic [3:0] TOKEN_ISSUE_PID,
  output logic [3:0] TOKEN_ISSUE_EP,
  output logic TOKEN_ISSUE_RX,
  output logic RESUME_DRIVE,
  output logic LS_EOP
);

  localparam int TIMER_W = $clog2(FRAME_CYCLES + 1);

  typedef struct packed
  {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic enable_bit;
    logic pp_reset;
    logic resume;
    logic host_mode;
    logic [3:0] token_pid;
    logic [3:0] token_ep;
    logic [FRAME_NUMBER_UPPER_W-1:0] frame_high;
    logic [TIMER_W-1:0] frame_timer;
    logic [FRAME_NUM_W-1:0] frame_count;
    logic [FRAME_NUM_W-1:0] sof_frame;
    logic sof_tx;
    logic module_enable;
    logic host_reset;
    logic ls_eop;
    logic tok_start;
  } state_t;

  state_t s;
  state_t next_s;
  logic tok_busy;

  // Exact word match; misaligned addresses fall out as unmapped
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // Bus phase decode
  logic access;
  logic commit;
  logic wr_ctl;
  logic wr_tok;
  assign access = PSEL && PENABLE;
  assign commit = access && s.pready;
  assign wr_ctl = commit && PWRITE && PSTRB[0] && reg_hit(PADDR, OFS_CONTROL);
  assign wr_tok = commit && PWRITE && PSTRB[0] && reg_hit(PADDR, OFS_TOKEN);

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block
  always_comb
  begin
    logic new_host;
    logic sof_en;
    new_host = s.host_mode;
    sof_en = 1'b0;
    next_s = s;
    next_s.sof_tx = 1'b0;
    next_s.ls_eop = 1'b0;
    next_s.host_reset = 1'b0;
    next_s.tok_start = 1'b0;

    // One wait state: ready comes in the second access cycle
    next_s.pready = access && !s.pready;
    next_s.pslverr = 1'b0;
    if (access && !s.pready)
    begin
      next_s.prdata = 32'h0000_0000;
      next_s.pslverr = !(reg_hit(PADDR, OFS_CONTROL) || reg_hit(PADDR, OFS_FRAME_HIGH)
                         || reg_hit(PADDR, OFS_TOKEN));
      if (!PWRITE)
      begin
        if (reg_hit(PADDR, OFS_CONTROL))
        begin
          next_s.prdata[CTL_ENABLE_BIT] = s.enable_bit;
          next_s.prdata[CTL_PP_RESET_BIT] = s.pp_reset;
          next_s.prdata[CTL_RESUME_BIT] = s.resume;
          next_s.prdata[CTL_HOST_BIT] = s.host_mode;
          next_s.prdata[CTL_BUSY_BIT] = tok_busy;
        end
        else if (reg_hit(PADDR, OFS_FRAME_HIGH))
          next_s.prdata[FRAME_NUMBER_UPPER_W-1:0] = s.frame_high;
        else if (reg_hit(PADDR, OFS_TOKEN))
        begin
          // Upper bits stay zero from the clear above
          next_s.prdata[TOK_PID_LSB +: TOK_FIELD_W] = s.token_pid;
          next_s.prdata[TOK_EP_LSB +: TOK_FIELD_W] = s.token_ep;
        end
      end
    end

    // Control register write; the busy bit is read only
    if (wr_ctl)
    begin
      new_host = PWDATA[CTL_HOST_BIT];
      next_s.enable_bit = PWDATA[CTL_ENABLE_BIT];
      next_s.pp_reset = PWDATA[CTL_PP_RESET_BIT];
      next_s.resume = PWDATA[CTL_RESUME_BIT];
      next_s.host_mode = new_host;
      // Either direction of the host bit resets host logic
      next_s.host_reset = (new_host != s.host_mode);
      // Dropping resume in host mode closes it with a low-speed EOP
      next_s.ls_eop = s.host_mode && s.resume && !PWDATA[CTL_RESUME_BIT];
    end

    // Token write; a write while busy is dropped so the fields match the bus
    if (wr_tok && !tok_busy)
    begin
      next_s.token_pid = PWDATA[TOK_PID_LSB +: TOK_FIELD_W];
      next_s.token_ep = PWDATA[TOK_EP_LSB +: TOK_FIELD_W];
      next_s.tok_start = s.host_mode;
    end

    // Enable: host mode keeps the module alive, else the device bit rules
    next_s.module_enable = next_s.host_mode || next_s.enable_bit;

    // Frame-start timer, cleared by host reset or when disabled
    sof_en = s.host_mode && s.enable_bit;
    if (next_s.host_reset || !sof_en)
    begin
      next_s.frame_timer = '0;
      if (next_s.host_reset)
        next_s.frame_count = FRAME_NUM_RESET;
    end
    else if (s.frame_timer == TIMER_W'(FRAME_CYCLES - 1))
    begin
      next_s.frame_timer = '0;
      next_s.sof_tx = 1'b1;
      next_s.sof_frame = s.frame_count;
      next_s.frame_count = s.frame_count + 11'h001;
    end
    else
      next_s.frame_timer = s.frame_timer + TIMER_W'(1);

    // Upper frame bits follow every received frame-start
    if (SOF_RX_VALID)
      next_s.frame_high = SOF_RX_FRAME[FRAME_NUM_W-1 -: FRAME_NUMBER_UPPER_W];
  end

  // State register; every field resets to zero
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      s <= '0;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Token sequencer, cleared one cycle after a host reset
  usb_token_engine u_engine
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .clear(s.host_reset),
    .start(s.tok_start),
    .pid(s.token_pid),
    .ep(s.token_ep),
    .done(TOKEN_DONE),
    .busy(tok_busy),
    .issue(TOKEN_ISSUE),
    .issue_pid(TOKEN_ISSUE_PID),
    .issue_ep(TOKEN_ISSUE_EP),
    .issue_rx(TOKEN_ISSUE_RX)
  );

  // Outputs straight from the state register
  assign PREADY = s.pready;
  assign PRDATA = s.prdata;
  assign PSLVERR = s.pslverr;
  assign MODULE_ENABLE = s.module_enable;
  assign PINGPONG_POINTER_RESET = s.pp_reset;
  assign HOST_LOGIC_RESET = s.host_reset;
  assign SOF_TX = s.sof_tx;
  assign SOF_TX_FRAME = s.sof_frame;
  assign RESUME_DRIVE = s.resume;
  assign LS_EOP = s.ls_eop;

  ////////////////////////////////////////////////////////////////////////////
  // Helper logic: cycles between frame-start tokens
  int sof_gap;
  logic sof_armed;
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sof_gap <= 0;
      sof_armed <= 1'b0;
    end
    else
    begin
      sof_gap <= SOF_TX ? 1 : sof_gap + 1;
      if (!(s.host_mode && s.enable_bit) || s.host_reset)
        sof_armed <= 1'b0;
      else if (SOF_TX)
        sof_armed <= 1'b1;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  // Single-cycle sequences
  sequence s_ctl_write;
    wr_ctl;
  endsequence

  sequence s_resume_dropped;
    wr_ctl && s.host_mode && s.resume && !PWDATA[CTL_RESUME_BIT];
  endsequence

  sequence s_token_accepted;
    wr_tok && !tok_busy && s.host_mode && pid_defined(PWDATA[TOK_PID_LSB +: TOK_FIELD_W]);
  endsequence

  property p_pp_reset;
    s_ctl_write |=> PINGPONG_POINTER_RESET == $past(PWDATA[CTL_PP_RESET_BIT]);
  endproperty
  a_pp_reset: assert property (p_pp_reset) else $error("pointer reset not following write");

  property p_device_enable;
    (s_ctl_write and !PWDATA[CTL_HOST_BIT]) |=> MODULE_ENABLE == $past(PWDATA[CTL_ENABLE_BIT]);
  endproperty
  a_device_enable: assert property (p_device_enable) else $error("enable wrong in device mode");

  property p_sof_only_enabled;
    SOF_TX |-> $past(s.host_mode) && $past(s.enable_bit);
  endproperty
  a_sof_only_enabled: assert property (p_sof_only_enabled) else $error("frame-start while disabled");

  property p_sof_period;
    SOF_TX && sof_armed |-> sof_gap == FRAME_CYCLES;
  endproperty
  a_sof_period: assert property (p_sof_period) else $error("frame-start spacing wrong");

  property p_host_reset;
    HOST_LOGIC_RESET |-> (s.host_mode != $past(s.host_mode)) ##1 !tok_busy;
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("host reset wrong");

  property p_ls_eop;
    s_resume_dropped |=> LS_EOP && !RESUME_DRIVE ##1 !LS_EOP;
  endproperty
  a_ls_eop: assert property (p_ls_eop) else $error("no low-speed EOP after resume");

  property p_frame_high;
    SOF_RX_VALID |=> s.frame_high == $past(SOF_RX_FRAME[FRAME_NUM_W-1 -: FRAME_NUMBER_UPPER_W]);
  endproperty
  a_frame_high: assert property (p_frame_high) else $error("frame high not captured");

  property p_frame_number_upper_upper_zero;
    PREADY && !PWRITE && reg_hit(PADDR, OFS_FRAME_HIGH) |-> PRDATA[31:FRAME_NUMBER_UPPER_W] == '0;
  endproperty
  a_frame_number_upper_upper_zero: assert property (p_frame_number_upper_upper_zero) else $error("frame high upper bits set");

  property p_token_upper_zero;
    PREADY && !PWRITE && reg_hit(PADDR, OFS_TOKEN) |-> PRDATA[31:8] == '0;
  endproperty
  a_token_upper_zero: assert property (p_token_upper_zero) else $error("token upper bits set");

  property p_token_start;
    s_token_accepted |=> ##1 TOKEN_ISSUE && tok_busy
      && TOKEN_ISSUE_PID == $past(PWDATA[TOK_PID_LSB +: TOK_FIELD_W], 2);
  endproperty
  a_token_start: assert property (p_token_start) else $error("token write did not issue");

  // Register side effects that the bus tests only see indirectly
  property p_token_fields_write;
    wr_tok && !tok_busy |=> s.token_pid == $past(PWDATA[TOK_PID_LSB +: TOK_FIELD_W])
      && s.token_ep == $past(PWDATA[TOK_EP_LSB +: TOK_FIELD_W]);
  endproperty
  a_token_fields_write: assert property (p_token_fields_write) else $error("token fields not stored");

  property p_token_drop_busy;
    wr_tok && tok_busy |=> $stable(s.token_pid) && $stable(s.token_ep);
  endproperty
  a_token_drop_busy: assert property (p_token_drop_busy) else $error("token changed while busy");

  property p_frame_count_reset;
    HOST_LOGIC_RESET |-> s.frame_count == FRAME_NUM_RESET && s.frame_timer == '0;
  endproperty
  a_frame_count_reset: assert property (p_frame_count_reset) else $error("frame counter kept over host reset");

  property p_sof_off;
    !(s.host_mode && s.enable_bit) |=> !SOF_TX;
  endproperty
  a_sof_off: assert property (p_sof_off) else $error("frame-start sent while off");

  property p_frame_number_upper_write_ignored;
    commit && PWRITE && reg_hit(PADDR, OFS_FRAME_HIGH) && !SOF_RX_VALID |=> $stable(s.frame_high);
  endproperty
  a_frame_number_upper_write_ignored: assert property (p_frame_number_upper_write_ignored) else $error("frame high took a write");

endmodule : usb_token_frame_control

`default_nettype wire

// *** dv/usb_bus_partner.sv ***
// Behavioural far side of the USB bus: answers tokens and sends frame starts
`timescale 1ns/1ps
`default_nettype none

module usb_bus_partner
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic token_issue,
  input wire logic [7:0] done_delay,
  input wire logic sof_req,
  input wire logic [10:0] sof_num,
  output logic token_done,
  output logic sof_valid,
  output logic [10:0] sof_frame
);
  logic [8:0] cnt;
  logic [10:0] last;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction ends a chosen number of cycles after issue, prompt or slow
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      token_done <= 1'b0;
    end
    else
    begin
      token_done <= (cnt == 9'h001);
      if (token_issue)
        cnt <= {1'b0, done_delay} + 9'h001;
      else if (cnt != 9'h000)
        cnt <= cnt - 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame number is valid only with the pulse; inverted junk otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sof_valid <= 1'b0;
      last <= '0;
    end
    else
    begin
      sof_valid <= sof_req;
      if (sof_req)
        last <= sof_num;
    end
  end
  assign sof_frame = sof_valid ? last : ~last;
endmodule : usb_bus_partner

`default_nettype wire

// *** dv/usb_token_frame_control_tb.sv ***
// Self-checking bench for the USB token and frame control block
`timescale 1ns/1ps
`default_nettype none

module usb_token_frame_control_tb;
  import usb_tfc_pkg::*;
  localparam int FC = 20;
  localparam int RES_HOLD = 25;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic PREADY, PSLVERR, SOF_RX_VALID, TOKEN_DONE, MODULE_ENABLE, PINGPONG_POINTER_RESET;
  logic HOST_LOGIC_RESET, SOF_TX, TOKEN_ISSUE, TOKEN_ISSUE_RX, RESUME_DRIVE, LS_EOP;
  logic [31:0] PRDATA, rd;
  logic [10:0] SOF_RX_FRAME, SOF_TX_FRAME, sof_fr;
  logic [3:0] TOKEN_ISSUE_PID, TOKEN_ISSUE_EP, i_pid, i_ep;
  logic i_rx, err;
  logic sof_req = 1'b0;
  logic [10:0] sof_num = 11'h000;
  logic [7:0] done_delay = 8'h01;
  logic [3:0] pids [3] = '{PID_SETUP, PID_IN, PID_OUT};
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_sof = 0;
  int n_iss = 0;
  int n_eop = 0;
  int n_hrst = 0;
  int sof_at = 0;
  int sof_gap = 0;
  int k;

  usb_token_frame_control #(.FRAME_CYCLES(FC)) u_usb_token_frame_control (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .SOF_RX_VALID(SOF_RX_VALID),
    .SOF_RX_FRAME(SOF_RX_FRAME), .TOKEN_DONE(TOKEN_DONE), .MODULE_ENABLE(MODULE_ENABLE),
    .PINGPONG_POINTER_RESET(PINGPONG_POINTER_RESET), .HOST_LOGIC_RESET(HOST_LOGIC_RESET), .SOF_TX(SOF_TX),
    .SOF_TX_FRAME(SOF_TX_FRAME), .TOKEN_ISSUE(TOKEN_ISSUE), .TOKEN_ISSUE_PID(TOKEN_ISSUE_PID),
    .TOKEN_ISSUE_EP(TOKEN_ISSUE_EP), .TOKEN_ISSUE_RX(TOKEN_ISSUE_RX), .RESUME_DRIVE(RESUME_DRIVE),
    .LS_EOP(LS_EOP));

  usb_bus_partner u_usb_bus_partner (.clk(REF_CLK), .rst_n(RST_N), .token_issue(TOKEN_ISSUE),
    .done_delay(done_delay), .sof_req(sof_req), .sof_num(sof_num), .token_done(TOKEN_DONE),
    .sof_valid(SOF_RX_VALID), .sof_frame(SOF_RX_FRAME));

  always #4 REF_CLK = ~REF_CLK;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse monitors sample pre-edge values; also the hang limit
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (SOF_TX === 1'b1)
    begin
      sof_gap = cyc - sof_at;
      sof_at = cyc;
      sof_fr = SOF_TX_FRAME;
      n_sof++;
    end
    if (TOKEN_ISSUE === 1'b1)
    begin
      i_pid = TOKEN_ISSUE_PID;
      i_ep = TOKEN_ISSUE_EP;
      i_rx = TOKEN_ISSUE_RX;
      n_iss++;
    end
    if (LS_EOP === 1'b1)
      n_eop++;
    if (HOST_LOGIC_RESET === 1'b1)
      n_hrst++;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for the slave however long it takes
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // Software polls busy before the next token; a stuck busy ends at the cycle limit
  task automatic wait_idle();
    do
    begin
      apb(1'b0, OFS_CONTROL, 32'h0);
    end while (rd[CTL_BUSY_BIT] !== 1'b0);
  endtask : wait_idle

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(posedge REF_CLK);
    RST_N <= 1'b1;
    apb(1'b0, OFS_TOKEN, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_TOKEN, 32'hFFFFFFFF);
    apb(1'b0, OFS_TOKEN, 32'h0);
    chk(rd, 32'h000000FF);
    apb(1'b1, OFS_FRAME_HIGH, 32'hFFFFFFFF);
    apb(1'b0, OFS_FRAME_HIGH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Device mode enable and pointer reset levels
    apb(1'b1, OFS_CONTROL, 32'h3);
    repeat (2) @(posedge REF_CLK);
    chk({30'h0, MODULE_ENABLE, PINGPONG_POINTER_RESET}, 32'h3);
    apb(1'b1, OFS_CONTROL, 32'h0);
    repeat (2) @(posedge REF_CLK);
    chk({30'h0, MODULE_ENABLE, PINGPONG_POINTER_RESET}, 32'h0);
    // Received frame starts refresh the upper frame bits
    sof_num <= 11'h5A3;
    sof_req <= 1'b1;
    @(posedge REF_CLK);
    sof_req <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    apb(1'b0, OFS_FRAME_HIGH, 32'h0);
    chk(rd, 32'h5);
    // Host mode entry pulses host reset; every token code issued
    apb(1'b1, OFS_CONTROL, 32'h8);
    repeat (2) @(posedge REF_CLK);
    chk(n_hrst, 1);
    for (k = 0; k < 3; k++)
    begin
      done_delay <= 8'(3 * k + 1);
      apb(1'b1, OFS_TOKEN, {24'h0, pids[k], 4'(k + 2)});
      wait_idle();
      chk(n_iss, k + 1);
      chk({23'h0, i_rx, i_pid, i_ep}, {23'h0, (k == 1), pids[k], 4'(k + 2)});
    end
    // Token write while busy is dropped
    done_delay <= 8'd30;
    apb(1'b1, OFS_TOKEN, 32'hD5);
    apb(1'b1, OFS_TOKEN, 32'h93);
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk({31'h0, rd[CTL_BUSY_BIT]}, 32'h1);
    apb(1'b0, OFS_TOKEN, 32'h0);
    chk(rd, 32'hD5);
    wait_idle();
    // Reserved code is stored but never issued
    apb(1'b1, OFS_TOKEN, 32'h27);
    repeat (6) @(posedge REF_CLK);
    chk(n_iss, 4);
    // Frame-start tokens at the frame period, none when disabled
    apb(1'b1, OFS_CONTROL, 32'h9);
    repeat (3 * FC + 5) @(posedge REF_CLK);
    chk(n_sof, 3);
    chk(sof_gap, FC);
    chk({21'h0, sof_fr}, 32'h2);
    apb(1'b1, OFS_CONTROL, 32'h8);
    k = n_sof;
    repeat (2 * FC + 5) @(posedge REF_CLK);
    chk(n_sof, k);
    // Resume held, then cleared: low-speed end-of-packet follows
    apb(1'b1, OFS_CONTROL, 32'hC);
    repeat (2) @(posedge REF_CLK);
    chk({31'h0, RESUME_DRIVE}, 32'h1);
    repeat (RES_HOLD) @(posedge REF_CLK);
    apb(1'b1, OFS_CONTROL, 32'h8);
    repeat (2) @(posedge REF_CLK);
    chk(n_eop, 1);
    chk({31'h0, RESUME_DRIVE}, 32'h0);
    // Leaving host mode mid-token resets host logic and clears busy
    done_delay <= 8'd60;
    apb(1'b1, OFS_TOKEN, 32'h13);
    apb(1'b1, OFS_CONTROL, 32'h0);
    repeat (2) @(posedge REF_CLK);
    chk(n_hrst, 2);
    chk(n_iss, 5);
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk({31'h0, rd[CTL_BUSY_BIT]}, 32'h0);
    conclude();
  end
endmodule : usb_token_frame_control_tb

`default_nettype wire
